// [core/strobed_matrix_display_shifter.sv]
// Top of the strobed matrix display shifter: chain, drivers, crossing
`timescale 1ns/1ns
module strobed_matrix_display_shifter
  import matrix_display_pkg::*;
#(
  parameter int CHARS = matrix_display_pkg::CHARS_PER_MODULE,  // Characters in module
  parameter int ROWS  = matrix_display_pkg::ROWS_PER_CHAR      // Rows per character
) (
  input  wire logic                    CLK_IN,          // System clock, 250 MHz
  input  wire logic                    RESET_N_IN,      // Asynchronous reset, active low
  input  wire logic                    LINK_CLK_IN,     // Shift clock from controller
  input  wire logic                    DATA_IN,         // Serial row data
  input  wire logic [matrix_display_pkg::COLUMNS-1:0] COLUMN_IN,  // Column strobes
  input  wire logic                    GATE_IN,         // Row driver gating level
  output logic                         DATA_OUT,        // Serial output to next module
  output logic [matrix_display_pkg::COLUMNS*matrix_display_pkg::CHARS_PER_MODULE*
                matrix_display_pkg::ROWS_PER_CHAR-1:0] LED_OUT  // Lit LEDs [col][char][row]
);
  import matrix_display_pkg::*;

  //------------------------------------------------------------
  // Link domain reset
  //------------------------------------------------------------
  logic link_rst_meta_q;  // First reset synchroniser flop
  logic link_rst_n_q;     // Released reset on link clock

  // Async assert, release on falling link edge
  always_ff @(negedge LINK_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      link_rst_meta_q <= 1'b0;
      link_rst_n_q    <= 1'b0;
    end else begin
      link_rst_meta_q <= 1'b1;
      link_rst_n_q    <= link_rst_meta_q;
    end
  end

  //------------------------------------------------------------
  // Shift chain
  //------------------------------------------------------------
  logic [CHARS*ROWS-1:0] chain;      // All stage outputs, char k at [k*ROWS +: ROWS]
  logic [CHARS:0]        stage_in;   // Serial links between stages

  // Character one is nearest DATA_IN; character four, shifted first, ends farthest
  assign stage_in[0] = DATA_IN;

  // One stage per character
  for (genvar c = 0; c < CHARS; c++) begin : g_stage
    serial_to_parallel_stage #(
      .WIDTH        (ROWS)
    ) u_stage (
      .link_clk_in  (LINK_CLK_IN),
      .link_rst_n_in(link_rst_n_q),
      .serial_in    (stage_in[c]),
      .parallel_out (chain[c*ROWS +: ROWS])
    );
    assign stage_in[c+1] = chain[c*ROWS + ROWS - 1];
  end

  // Serial output: bit seven of the farthest stage, which is character four
  logic data_out_q;  // Serial output flop on link clock
  logic data_out_d;  // Next serial output

  // Passes character four's last bit onward
  always_comb begin
    data_out_d = chain[CHARS*ROWS-1];
  end

  // Captured on rising link edge, half period after the shift
  always_ff @(posedge LINK_CLK_IN or negedge link_rst_n_q) begin
    if (!link_rst_n_q) begin
      data_out_q <= 1'b0;
    end else begin
      data_out_q <= data_out_d;
    end
  end

  //------------------------------------------------------------
  // Crossing of row data into system clock domain
  //------------------------------------------------------------
  logic [CHARS*ROWS-1:0] chain_meta_q;  // First sync flop
  logic [CHARS*ROWS-1:0] chain_sync_q;  // Second sync flop
  logic [COLUMNS-1:0]    col_meta_q;    // First sync flop for strobes
  logic [COLUMNS-1:0]    col_sync_q;    // Second sync flop for strobes
  logic                  gate_meta_q;   // First sync flop for gating
  logic                  gate_sync_q;   // Second sync flop for gating

  // Two-flop synchronisers; strobes are off while shifting, so the
  // row word is quiet whenever it is displayed
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      chain_meta_q <= '0;
      chain_sync_q <= '0;
      col_meta_q   <= '0;
      col_sync_q   <= '0;
      gate_meta_q  <= 1'b0;
      gate_sync_q  <= 1'b0;
    end else begin
      chain_meta_q <= chain;
      chain_sync_q <= chain_meta_q;
      col_meta_q   <= COLUMN_IN;
      col_sync_q   <= col_meta_q;
      gate_meta_q  <= GATE_IN;
      gate_sync_q  <= gate_meta_q;
    end
  end

  //------------------------------------------------------------
  // Row drivers and column matrix
  //------------------------------------------------------------
  logic [COLUMNS*CHARS*ROWS-1:0] led_q;  // Registered LED states
  logic [COLUMNS*CHARS*ROWS-1:0] led_d;  // Next LED states

  // LED lit when its row bit is one, gate high and column strobed
  always_comb begin
    led_d = '0;
    for (int col = 0; col < COLUMNS; col++) begin
      for (int c = 0; c < CHARS; c++) begin
        for (int r = 0; r < ROWS; r++) begin
          // Chain stage c lights character c+1; col strobe shared by all chars
          led_d[(col*CHARS + c)*ROWS + r] =
            chain_sync_q[c*ROWS + r] & gate_sync_q & col_sync_q[col];
        end
      end
    end
  end

  // Register the LED matrix
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      led_q <= '0;
    end else begin
      led_q <= led_d;
    end
  end

  assign DATA_OUT = data_out_q;
  assign LED_OUT  = led_q;

  //------------------------------------------------------------
  // Assertions
  //------------------------------------------------------------
  // Checks are grouped by clock domain. Link side shift, load, trip and
  // cascade checks run on the falling shift edge, so sampled values are the contents just before
  // each shift. Display side checks run on the system clock; all but the strobe
  // latency and reset checks look at the synchronised copies, two system cycles behind the pins.

  //------------------------------------------------------------
  // Link side helpers
  //------------------------------------------------------------
  logic link_rst_past_q;  // Helper: reset released one link cycle ago

  // Set one falling edge after the link reset releases, so that no
  // sampled history reaches back into the reset period
  always_ff @(negedge LINK_CLK_IN or negedge link_rst_n_q) begin
    if (!link_rst_n_q) begin
      link_rst_past_q <= 1'b0;
    end else begin
      link_rst_past_q <= 1'b1;
    end
  end

  // A shift edge with a clean history behind it
  sequence s_shift_ready;
    link_rst_past_q;
  endsequence

  // A shift edge followed by one full trip along the chain; the count
  // equals the chain length of the default four-character module
  sequence s_full_trip;
    s_shift_ready ##28 1'b1;
  endsequence

  //------------------------------------------------------------
  // Link side checks
  //------------------------------------------------------------
  // Every location but the first takes the one before it on each falling edge
  a_chain_shift_step: assert property (
    @(negedge LINK_CLK_IN) disable iff (!link_rst_n_q)
      link_rst_past_q |=> chain[CHARS*ROWS-1:1] == $past(chain[CHARS*ROWS-2:0]))
    else $error("Chain did not shift by one on falling edge");

  // Location one of the first stage takes the serial input
  a_chain_serial_load: assert property (
    @(negedge LINK_CLK_IN) disable iff (!link_rst_n_q)
      link_rst_past_q |=> chain[0] == $past(DATA_IN))
    else $error("First location did not take the serial input");

  // A bit shifted in reaches the last location after a full trip,
  // which is what lets a cascade see whole characters
  a_bit_reaches_end: assert property (
    @(negedge LINK_CLK_IN) disable iff (!link_rst_n_q)
      s_full_trip |-> chain[CHARS*ROWS-1] == $past(DATA_IN, 28))
    else $error("Bit did not reach the end of the chain");

  // While the shift clock stands high the chain keeps its contents,
  // whatever the strobes and the gate do
  a_link_idle_hold: assert property (
    @(posedge CLK_IN) disable iff (!link_rst_n_q)
      (LINK_CLK_IN && $past(LINK_CLK_IN)) |-> $stable(chain))
    else $error("Chain changed without a falling edge");

  // Serial output follows the last location, registered on the rise
  a_serial_out_tap: assert property (
    @(posedge LINK_CLK_IN) disable iff (!link_rst_n_q)
      1'b1 |=> DATA_OUT == $past(chain[CHARS*ROWS-1]))
    else $error("Serial output not bit seven of character four");

  // At each falling edge the next module sees the settled last bit
  a_cascade_out_level: assert property (
    @(negedge LINK_CLK_IN) disable iff (!link_rst_n_q)
      link_rst_past_q |-> DATA_OUT == chain[CHARS*ROWS-1])
    else $error("Cascade output not settled at the shift edge");

  // Link reset empties the chain
  a_link_reset_clear: assert property (
    @(posedge CLK_IN)
      !link_rst_n_q |-> chain == '0)
    else $error("Chain not empty during link reset");

  // Serial output stays low during link reset
  a_serial_out_reset: assert property (
    @(posedge CLK_IN)
      !link_rst_n_q |-> DATA_OUT == 1'b0)
    else $error("Serial output not low during link reset");

  //------------------------------------------------------------
  // Display side checks
  //------------------------------------------------------------
  // Gate low turns every row driver off
  a_gate_off_dark: assert property (
    @(posedge CLK_IN) disable iff (!RESET_N_IN)
      !gate_sync_q |=> LED_OUT == '0)
    else $error("LEDs lit while row drivers gated off");

  // Gate high with the last column strobed shows the whole stored image in that column
  a_gate_on_lights: assert property (
    @(posedge CLK_IN) disable iff (!RESET_N_IN)
      (gate_sync_q && col_sync_q[COLUMNS-1]) |=>
        LED_OUT[COLUMNS*CHARS*ROWS-1 -: CHARS*ROWS] == $past(chain_sync_q))
    else $error("Strobed column does not show the stored image");

  // Rows of character one follow its stored bits
  a_row_follows_bit: assert property (
    @(posedge CLK_IN) disable iff (!RESET_N_IN)
      (gate_sync_q && col_sync_q[0]) |=> LED_OUT[ROWS-1:0] == $past(chain_sync_q[ROWS-1:0]))
    else $error("Row drivers do not follow stored bits");

  // Character four shows the farthest stage, the one shifted in first
  a_char_four_place: assert property (
    @(posedge CLK_IN) disable iff (!RESET_N_IN)
      (gate_sync_q && col_sync_q[0]) |=>
        LED_OUT[CHARS*ROWS-1 -: ROWS] == $past(chain_sync_q[CHARS*ROWS-1 -: ROWS]))
    else $error("Character four not shown from the farthest stage");

  // The last column stays dark while its strobe is low
  a_column_shared: assert property (
    @(posedge CLK_IN) disable iff (!RESET_N_IN)
      !col_sync_q[COLUMNS-1] |=> LED_OUT[COLUMNS*CHARS*ROWS-1 -: CHARS*ROWS] == '0)
    else $error("Unstrobed column lit");

  // Every column stays dark in all characters while its strobe is low
  for (genvar k = 0; k < COLUMNS; k++) begin : g_column_check
    a_column_dark: assert property (
      @(posedge CLK_IN) disable iff (!RESET_N_IN)
        !col_sync_q[k] |=> LED_OUT[k*CHARS*ROWS +: CHARS*ROWS] == '0)
      else $error("Unstrobed column lit");
  end

  // Strobes low at the pins for three cycles leave the display dark
  a_strobe_latency: assert property (
    @(posedge CLK_IN) disable iff (!RESET_N_IN)
      (COLUMN_IN == '0) [*3] |=> LED_OUT == '0)
    else $error("LEDs lit three cycles after all strobes off");

  // Reset keeps every LED off
  a_leds_in_reset: assert property (
    @(posedge CLK_IN)
      !RESET_N_IN |-> LED_OUT == '0)
    else $error("LEDs lit during reset");
endmodule : strobed_matrix_display_shifter

// [core/matrix_display_pkg.sv]
// Package of constants for the strobed matrix display shifter
//------------------------------------------------------------
// Overview of operation
// - Seven-bit shift stage per character, four characters
// - Chain advances on falling link clock only
// - Serial out is character four bit seven
// - Stored one turns row driver on
// - Five column lines shared by all characters
// - Cascades up to 80 characters supported
// - Gating input high enables row drivers
//------------------------------------------------------------
package matrix_display_pkg;
  localparam int ROWS_PER_CHAR    = 7;    // Rows per character
  localparam int CHARS_PER_MODULE = 4;    // Characters per module
  localparam int COLUMNS          = 5;    // Shared column lines
  localparam int CHAIN_BITS       = ROWS_PER_CHAR * CHARS_PER_MODULE;
  localparam int MAX_STRING_CHARS = 80;   // Longest cascaded string
  localparam int SYNC_STAGES      = 2;    // Synchroniser depth
  localparam logic [CHAIN_BITS-1:0] CHAIN_RESET = '0; // Link side reset value
endpackage : matrix_display_pkg

// [core/serial_to_parallel_stage.sv]
// One seven-bit serial-in parallel-out shift stage on the link clock
`timescale 1ns/1ns
module serial_to_parallel_stage #(
  parameter int WIDTH = 7                       // Bits in the stage
) (
  input  wire logic             link_clk_in,    // Shift clock from controller
  input  wire logic             link_rst_n_in,  // Link domain reset
  input  wire logic             serial_in,      // Bit from previous stage
  output logic [WIDTH-1:0]      parallel_out    // Row bits, bit 0 is location 1
);
  logic [WIDTH-1:0] bits_q;  // Stage contents
  logic [WIDTH-1:0] bits_d;  // Next contents

  // Shift toward higher locations
  always_comb begin
    bits_d = {bits_q[WIDTH-2:0], serial_in};
  end

  // Falling edge only; holds between edges
  always_ff @(negedge link_clk_in or negedge link_rst_n_in) begin
    if (!link_rst_n_in) begin
      bits_q <= '0;
    end else begin
      bits_q <= bits_d;
    end
  end

  assign parallel_out = bits_q;
endmodule : serial_to_parallel_stage

// [tb/display_controller.sv]
// Behavioural controller that clocks column row bits into the display
`timescale 1ns/1ns
module display_controller (
  output logic link_clk_out,  // Shift clock, stands high between frames
  output logic data_out       // Serial row data
);
  //----------------------------------------
  // Idle levels
  //----------------------------------------
  initial begin
    link_clk_out = 1'b1;
    data_out     = 1'b0;
  end
  // Shifts n bits, word bit 27 first; with n of 28 the whole word ends up as the chain image
  task automatic load(input logic [27:0] w, input int n);
    #13;
    for (int i = 0; i < n; i++) begin
      data_out = w[27-i];
      #40 link_clk_out = 1'b0;
      #30 data_out = ~data_out;  // Hold spent: the line no longer shows the bit
      #10 link_clk_out = 1'b1;
    end
  endtask : load
endmodule : display_controller

// [tb/tb.sv]
// Self-checking bench for the strobed matrix display shifter
`timescale 1ns/1ns
module tb;
  import matrix_display_pkg::*;
  logic         clk         = 1'b0;   // System clock
  logic         reset_n     = 1'b0;   // Active-low reset
  logic [4:0]   column      = 5'h00;  // Column strobes
  logic         gate        = 1'b0;   // Row driver gate
  wire logic    link_clk;             // Shift clock from controller
  wire logic    ser_data;             // Serial row data
  logic         data_out;             // Cascade output
  logic [139:0] led;                  // Lit LEDs
  int           bad_count   = 0;      // Mismatches
  int           check_count = 0;      // Comparisons
  localparam logic [27:0] PAT [5] = '{28'h8000001, 28'h5555555, 28'haaaaaaa, 28'hfffffff, 28'h0c3a5f1};
  //----------------------------------------
  // Clock, partner and design
  //----------------------------------------
  always #2 clk = ~clk;
  display_controller ctl (.link_clk_out(link_clk), .data_out(ser_data));
  strobed_matrix_display_shifter dut (
    .CLK_IN(clk), .RESET_N_IN(reset_n), .LINK_CLK_IN(link_clk), .DATA_IN(ser_data),
    .COLUMN_IN(column), .GATE_IN(gate), .DATA_OUT(data_out), .LED_OUT(led));
  // Expected lit LEDs for one strobed column holding chain image w;
  // chain stage s, counted from the serial input, lights character s+1
  function automatic logic [139:0] exp_led(input logic [27:0] w, input int col);
    logic [139:0] e;
    e = '0;
    for (int s = 0; s < 4; s++)
      e[col*28+s*7 +: 7] = w[s*7 +: 7];
    return e;
  endfunction : exp_led
  task automatic chk_led(input logic [139:0] got, input logic [139:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_led
  task automatic chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_bit
  // Load and strobe each of the five columns in turn, strobes off while shifting
  task automatic scen_columns;
    time t0;  // Start of the refresh pass
    t0 = $time;
    for (int c = 0; c < 5; c++) begin
      ctl.load(PAT[c], 28);
      @(negedge clk) column = 5'h01 << c;
      repeat (4) @(negedge clk);
      chk_led(led, exp_led(PAT[c], c));
      chk_bit(data_out, PAT[c][27]);
      column = 5'h00;
      repeat (4) @(negedge clk);
      chk_led(led, '0);
    end
    chk_bit(($time - t0) < 64'd10000000, 1'b1);
  endtask : scen_columns
  // Gate off blanks the rows; image survives without link clocks
  task automatic scen_gate;
    @(negedge clk) column = 5'h10;
    repeat (4) @(negedge clk);
    gate = 1'b0;
    repeat (4) @(negedge clk);
    chk_led(led, '0);
    gate = 1'b1;
    repeat (4) @(negedge clk);
    chk_led(led, exp_led(PAT[4], 4));
    column = 5'h00;
  endtask : scen_gate
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict
  //----------------------------------------
  // Main sequence and watchdog
  //----------------------------------------
  initial begin
    repeat (16) @(negedge clk);
    reset_n = 1'b1;
    gate = 1'b1;
    ctl.load(28'h0000000, 2);  // Two edges release the link-side reset
    scen_columns();
    scen_gate();
    give_verdict();
  end
  initial begin
    #100000;
    bad_count++;
    give_verdict();
  end
endmodule : tb
